/* scl_pkg.sv */
package scl_pkg;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0]  SCL_CFG_OFS        = 4'h0;  // Channel config word
  localparam logic [3:0]  SCL_CTL_OFS        = 4'h4;  // Bypass control word
  localparam logic [3:0]  SCL_STS_OFS        = 4'h8;  // Status word
  // ==========================================================================
  // Field positions of the channel config word
  // ==========================================================================
  localparam int          SCL_HALF_RATE_BIT  = 0;
  localparam int          SCL_RECALC_BIT     = 1;
  localparam int          SCL_CLK_ALIGN_BIT  = 2;
  localparam int          SCL_ATTEN_LSB      = 5;
  localparam int          SCL_TXEN_LSB       = 9;
  localparam int          SCL_BOOST_LSB      = 12;
  localparam int          SCL_PLL_PWR_BIT    = 16;
  localparam int          SCL_RXEN_BIT       = 17;
  localparam int          SCL_DPLL_CLR_BIT   = 18;
  localparam int          SCL_RSV19_LSB      = 19;
  localparam int          SCL_EQ_LSB         = 21;
  localparam int          SCL_DPLL_SEL_LSB   = 24;
  localparam int          SCL_TXCLK_PWR_BIT  = 27;
  localparam int          SCL_LOSS_LSB       = 28;
  localparam int          SCL_ALIGN_BIT      = 30;
  localparam int          SCL_RSV31_BIT      = 31;
  // ==========================================================================
  // Field reset values
  // ==========================================================================
  localparam logic        SCL_HALF_RATE_RST  = 1'h0;
  localparam logic        SCL_RECALC_RST     = 1'h0;
  localparam logic        SCL_CLK_ALIGN_RST  = 1'h1;
  localparam logic [2:0]  SCL_ATTEN_RST      = 3'h0;
  localparam logic [2:0]  SCL_TXEN_RST       = 3'h3;
  localparam logic [3:0]  SCL_BOOST_RST      = 4'hC;
  localparam logic        SCL_PLL_PWR_RST    = 1'h1;
  localparam logic        SCL_RXEN_RST       = 1'h1;
  localparam logic        SCL_DPLL_CLR_RST   = 1'h1;
  localparam logic [1:0]  SCL_RSV19_RST      = 2'h0;
  localparam logic [2:0]  SCL_EQ_RST         = 3'h5;
  localparam logic [2:0]  SCL_DPLL_SEL_RST   = 3'h0;
  localparam logic        SCL_TXCLK_PWR_RST  = 1'h1;
  localparam logic [1:0]  SCL_LOSS_RST       = 2'h0;
  localparam logic        SCL_ALIGN_RST      = 1'h1;
  localparam logic        SCL_RSV31_RST      = 1'h1;
  localparam logic        SCL_BYPASS_RST     = 1'h0;
  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam logic [2:0]  SCL_TXEN_OFF       = 3'h0;
  localparam logic [2:0]  SCL_TXEN_ON        = 3'h3;
  localparam logic [2:0]  SCL_ATTEN_MAX      = 3'h5;  // 11x reserved above
  localparam logic [1:0]  SCL_LOSS_OFF       = 2'h0;
  localparam logic [1:0]  SCL_LOSS_HEAVY     = 2'h3;
  localparam logic [1:0]  SCL_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  SCL_RESP_SLVERR    = 2'h2;
  localparam logic [31:0] SCL_ZERO_WORD      = 32'h0000_0000;
endpackage

/* scl_edge_pulse.sv */
// ============================================================================
// Rising-edge pulse of a software written level
// ============================================================================
module scl_edge_pulse
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level and its reset value
  input  wire logic level,
  input  wire logic level_rst,
  // One-cycle pulse on 0 to 1
  output logic      rise_pulse
);
  logic prev_q;

  // Previous level starts at the field reset value, so a field that resets
  // high does not look like a fresh 0 to 1 edge once reset is released
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_q <= level_rst;
    else
      prev_q <= level;
  end

  // Armed flag avoids a pulse in the first cycle after reset
  logic armed_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      armed_q <= 1'b0;
    else
      armed_q <= 1'b1;
  end

  assign rise_pulse = armed_q & level & ~prev_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_edge_pulse;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(level) && $past(aresetn)) |-> rise_pulse;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse)
    else $error("rising level gave no pulse");

  property p_pulse_single;
    @(posedge aclk) disable iff (!aresetn)
    rise_pulse |=> !rise_pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("edge pulse longer than one cycle");

  property p_pulse_cause;
    @(posedge aclk) disable iff (!aresetn)
    rise_pulse |-> (level && !$past(level));
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("edge pulse without rising level");
endmodule

/* scl_lane_config.sv */
module scl_lane_config
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Transceiver status (asynchronous)
  input  wire logic        rx_pll_locked,
  // Transceiver controls
  output logic             half_rate,
  output logic             drive_recalc_pulse,
  output logic [2:0]       drive_attenuation,
  output logic [2:0]       tx_enable,
  output logic [3:0]       tx_boost,
  output logic             rx_pll_power,
  output logic             rx_output_enable,
  output logic             dpll_frequency_clear,
  output logic [2:0]       receive_equalizer_level,
  output logic [2:0]       receive_dpll_select,
  output logic             transmit_clock_power,
  output logic [1:0]       signal_loss_filter,
  output logic             word_align_enable
);
  import scl_pkg::*;

  // ==========================================================================
  // Register fields
  // ==========================================================================
  logic       half_rate_q;
  logic       recalc_q;
  logic       clk_align_q;
  logic [2:0] atten_q;
  logic [2:0] txen_q;
  logic [3:0] boost_q;
  logic       pll_pwr_q;
  logic       rxen_q;
  logic       dpll_clr_q;
  logic [1:0] rsv19_q;
  logic [2:0] eq_q;
  logic [2:0] dpll_sel_q;
  logic       txclk_pwr_q;
  logic [1:0] loss_q;
  logic       align_q;
  logic       rsv31_q;
  logic       bypass_q;
  logic       lock_s1_q;
  logic       lock_s2_q;
  logic [31:0] cfg_word;

  // ==========================================================================
  // Write channel
  // ==========================================================================
  logic       aw_held_q;
  logic [3:0] aw_addr_q;
  logic       w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_go;
  logic [31:0] wr_mask;
  logic [31:0] wr_new;

  // Address and data accepted independently, one write in flight
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
  assign wr_go         = aw_held_q & w_held_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      w_data_q <= SCL_ZERO_WORD;
      w_strb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held_q <= 1'b0;
  end

  // Response: unmapped offsets answer SLVERR and change nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SCL_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q == SCL_CFG_OFS || aw_addr_q == SCL_CTL_OFS)
                      ? SCL_RESP_OKAY : SCL_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Byte-lane merge of the write data into the current word
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wr_mask[gi*8 +: 8] = {8{w_strb_q[gi]}};
    end
  endgenerate
  assign wr_new = (w_data_q & wr_mask) | (cfg_word & ~wr_mask);

  // ==========================================================================
  // Channel config fields; the word has no reset of its own, only fields
  // ==========================================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      half_rate_q <= SCL_HALF_RATE_RST;
      recalc_q    <= SCL_RECALC_RST;
      clk_align_q <= SCL_CLK_ALIGN_RST;
      atten_q     <= SCL_ATTEN_RST;
      txen_q      <= SCL_TXEN_RST;
      boost_q     <= SCL_BOOST_RST;
      pll_pwr_q   <= SCL_PLL_PWR_RST;
      rxen_q      <= SCL_RXEN_RST;
      dpll_clr_q  <= SCL_DPLL_CLR_RST;
      rsv19_q     <= SCL_RSV19_RST;
      eq_q        <= SCL_EQ_RST;
      dpll_sel_q  <= SCL_DPLL_SEL_RST;
      txclk_pwr_q <= SCL_TXCLK_PWR_RST;
      loss_q      <= SCL_LOSS_RST;
      align_q     <= SCL_ALIGN_RST;
      rsv31_q     <= SCL_RSV31_RST;
    end
    else if (wr_go && aw_addr_q == SCL_CFG_OFS)
    begin
      // Values are stored as written so software reads them back
      half_rate_q <= wr_new[SCL_HALF_RATE_BIT];
      recalc_q    <= wr_new[SCL_RECALC_BIT];
      clk_align_q <= wr_new[SCL_CLK_ALIGN_BIT];
      atten_q     <= wr_new[SCL_ATTEN_LSB +: 3];
      txen_q      <= wr_new[SCL_TXEN_LSB +: 3];
      boost_q     <= wr_new[SCL_BOOST_LSB +: 4];
      pll_pwr_q   <= wr_new[SCL_PLL_PWR_BIT];
      rxen_q      <= wr_new[SCL_RXEN_BIT];
      dpll_clr_q  <= wr_new[SCL_DPLL_CLR_BIT];
      rsv19_q     <= wr_new[SCL_RSV19_LSB +: 2];
      eq_q        <= wr_new[SCL_EQ_LSB +: 3];
      dpll_sel_q  <= wr_new[SCL_DPLL_SEL_LSB +: 3];
      txclk_pwr_q <= wr_new[SCL_TXCLK_PWR_BIT];
      loss_q      <= wr_new[SCL_LOSS_LSB +: 2];
      align_q     <= wr_new[SCL_ALIGN_BIT];
      rsv31_q     <= wr_new[SCL_RSV31_BIT];
    end
  end

  // Bypass-initialisation control lives in its own word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bypass_q <= SCL_BYPASS_RST;
    else if (wr_go && aw_addr_q == SCL_CTL_OFS && w_strb_q[0])
      bypass_q <= w_data_q[0];
  end

  // Read image: bits 8, 4 and 3 are read-only zero
  assign cfg_word = {rsv31_q, align_q, loss_q, txclk_pwr_q, dpll_sel_q,
                     eq_q, rsv19_q, dpll_clr_q, rxen_q, pll_pwr_q,
                     boost_q, txen_q, 1'b0, atten_q, 2'b00,
                     clk_align_q, recalc_q, half_rate_q};

  // ==========================================================================
  // PLL lock synchroniser
  // ==========================================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end
    else
    begin
      lock_s1_q <= rx_pll_locked;
      lock_s2_q <= lock_s1_q;
    end
  end

  // ==========================================================================
  // Rising-edge strobes
  // ==========================================================================
  logic dpll_clr_pulse;

  scl_edge_pulse u_recalc_edge
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .level      (recalc_q),
    .level_rst  (SCL_RECALC_RST),
    .rise_pulse (drive_recalc_pulse)
  );

  scl_edge_pulse u_dpll_edge
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .level      (dpll_clr_q),
    .level_rst  (SCL_DPLL_CLR_RST),
    .rise_pulse (dpll_clr_pulse)
  );

  // ==========================================================================
  // Transceiver control lines
  // ==========================================================================
  assign half_rate               = half_rate_q;
  assign drive_attenuation       = atten_q;
  assign tx_boost                = boost_q;
  assign dpll_frequency_clear    = dpll_clr_pulse;
  assign receive_equalizer_level = eq_q;
  assign receive_dpll_select     = dpll_sel_q;
  assign transmit_clock_power    = txclk_pwr_q;
  assign signal_loss_filter      = loss_q;
  assign word_align_enable       = align_q;

  // Without bypass the init sequencer owns these; hold them at safe reset
  // values here rather than let software drive the analogue directly
  assign tx_enable    = bypass_q ? txen_q : SCL_TXEN_RST;
  assign rx_pll_power = bypass_q ? pll_pwr_q : SCL_PLL_PWR_RST;
  // Receive output gated until PLL is powered and locked
  assign rx_output_enable = bypass_q & rxen_q & pll_pwr_q
                            & lock_s2_q;

  // ==========================================================================
  // Read channel
  // ==========================================================================
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= SCL_ZERO_WORD;
      s_axi_rresp  <= SCL_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= SCL_RESP_OKAY;
      case (s_axi_araddr)
        SCL_CFG_OFS: s_axi_rdata <= cfg_word;
        SCL_CTL_OFS: s_axi_rdata <= {31'h0000_0000, bypass_q};
        SCL_STS_OFS: s_axi_rdata <= {30'h0000_0000, lock_s2_q,
                                     rx_output_enable};
        default:
        begin
          s_axi_rdata <= SCL_ZERO_WORD;
          s_axi_rresp <= SCL_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_bypass_gate;
    @(posedge aclk) disable iff (!aresetn)
    !bypass_q |-> (tx_enable == SCL_TXEN_RST && !rx_output_enable);
  endproperty
  a_bypass_gate: assert property (p_bypass_gate)
    else $error("controls reached transceiver without bypass");

  property p_rxen_lock;
    @(posedge aclk) disable iff (!aresetn)
    rx_output_enable |-> (rx_pll_power && lock_s2_q);
  endproperty
  a_rxen_lock: assert property (p_rxen_lock)
    else $error("rx enable without pll power and lock");

  property p_write_cfg;
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && aw_addr_q == SCL_CFG_OFS && w_strb_q[3] && w_strb_q[2])
      |=> (eq_q == w_data_q[SCL_EQ_LSB +: 3]
           && align_q == w_data_q[SCL_ALIGN_BIT]);
  endproperty
  a_write_cfg: assert property (p_write_cfg)
    else $error("config write not stored");

  property p_readback;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == SCL_CFG_OFS)
      |=> (s_axi_rvalid && s_axi_rdata[8] == 1'b0 && s_axi_rdata[4:3] == 2'b00
           && s_axi_rdata[15:12] == $past(boost_q));
  endproperty
  a_readback: assert property (p_readback)
    else $error("config readback wrong");

  property p_pass_fields;
    @(posedge aclk) disable iff (!aresetn)
    ##1 (half_rate == half_rate_q && signal_loss_filter == loss_q
         && drive_attenuation == cfg_word[7:5]
         && transmit_clock_power == cfg_word[27]);
  endproperty
  a_pass_fields: assert property (p_pass_fields)
    else $error("field not driven to transceiver");
endmodule

/* test_serdes_lane_config_register.sv */
module test_serdes_lane_config_register
  import scl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic        aclk;
  logic        aresetn;
  logic [3:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [3:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        rx_pll_locked;
  logic        half_rate;
  logic        drive_recalc_pulse;
  logic [2:0]  drive_attenuation;
  logic [2:0]  tx_enable;
  logic [3:0]  tx_boost;
  logic        rx_pll_power;
  logic        rx_output_enable;
  logic        dpll_frequency_clear;
  logic [2:0]  receive_equalizer_level;
  logic [2:0]  receive_dpll_select;
  logic        transmit_clock_power;
  logic [1:0]  signal_loss_filter;
  logic        word_align_enable;
  logic [22:0] outs;
  int          err_total;
  int          checks;
  int          recalc_cnt = 0;
  int          clear_cnt = 0;
  localparam logic [31:0] BASE = 32'hC8A7_C604;  // Field reset image

  // All level controls gathered for one comparison
  assign outs = {half_rate, drive_attenuation, tx_enable, tx_boost,
                 rx_pll_power, rx_output_enable, receive_equalizer_level,
                 receive_dpll_select, transmit_clock_power,
                 signal_loss_filter, word_align_enable};

  scl_lane_config i_scl_lane_config (.*);

  // ==========================================================================
  // Clock, pulse counters and watchdog
  // ==========================================================================
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Counted at the falling edge so the pulse has settled
  always @(negedge aclk)
  begin
    if (drive_recalc_pulse === 1'b1) recalc_cnt++;
    if (dpll_frequency_clear === 1'b1) clear_cnt++;
  end

  // Whole run needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    stop_test();
  end

  // ==========================================================================
  // Compare and bus tasks
  // ==========================================================================
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t response %h expected %h", $time, got, exp);
    end
  endtask

  // Ready is sampled mid-cycle; the taking edge is the next rising one
  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data,
                           input logic [3:0] strb, output logic [1:0] resp);
    logic ta;
    logic tw;
    logic tb;
    logic done;
    @(posedge aclk);
    s_axi_awaddr  <= addr;
    s_axi_wdata   <= data;
    s_axi_wstrb   <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      done = tb;
    end
  endtask

  task automatic axi_read(input logic [3:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    logic ta;
    logic tr;
    @(posedge aclk);
    s_axi_araddr  <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    logic [1:0] r;
    axi_write(addr, data, 4'hF, r);
    chk_resp(r, SCL_RESP_OKAY);
  endtask

  // Reads the config word and compares outputs with what it implies
  task automatic check_all(input logic [31:0] exp, input logic byp,
                           input logic lock);
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  txen;
    txen = byp ? exp[11:9] : SCL_TXEN_ON;
    @(negedge aclk);
    chk_word({9'h000, outs}, {9'h000, exp[0], exp[7:5], txen, exp[15:12],
             (byp ? exp[16] : 1'b1), byp & exp[17] & exp[16] & lock,
             exp[23:21], exp[26:24], exp[27], exp[29:28], exp[30]});
    axi_read(SCL_CFG_OFS, d, r);
    chk_word(d, exp);
    chk_resp(r, SCL_RESP_OKAY);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_fields;
    logic [31:0] w;
    for (int i = 0; i <= 5; i++)
    begin
      // Receive output kept off while the DPLL select moves
      w = BASE & ~32'h0702_0000;
      w = w | 32'(i) << 24 | 32'(i) << 21 | 32'(i) << 5 | 32'(i) << 12;
      w = w & ~32'h4000_0000 | (i[0] ? 32'h3000_0001 : 32'h4000_0000);
      wr(SCL_CFG_OFS, w);
      check_all(w, 1'b0, 1'b0);
    end
  endtask

  task automatic t_readback;
    logic [1:0]  r;
    logic [31:0] d;
    wr(SCL_CFG_OFS, 32'hFFFF_FFFF);
    check_all(32'hFFFF_FEE7, 1'b0, 1'b0);
    axi_write(SCL_CFG_OFS, 32'h0000_0000, 4'h2, r);
    chk_resp(r, SCL_RESP_OKAY);
    check_all(32'hFFFF_00E7, 1'b0, 1'b0);
    axi_write(4'hC, 32'h0000_0000, 4'hF, r);
    chk_resp(r, SCL_RESP_SLVERR);
    axi_read(4'hC, d, r);
    chk_resp(r, SCL_RESP_SLVERR);
    chk_word(d, SCL_ZERO_WORD);
    check_all(32'hFFFF_00E7, 1'b0, 1'b0);
  endtask

  // Counts are taken relative to snapshots so only the counter process
  // ever writes them
  task automatic t_pulses;
    int rc;
    int cc;
    wr(SCL_CFG_OFS, 32'hFFFD_00E7);
    wr(SCL_CFG_OFS, BASE & ~32'h0002_0000);
    wr(SCL_CFG_OFS, BASE);
    rc = recalc_cnt;
    cc = clear_cnt;
    wr(SCL_CFG_OFS, BASE & ~32'h0004_0000);
    repeat (4) @(posedge aclk);
    chk_word(32'(recalc_cnt + clear_cnt - rc - cc), 32'h0);
    wr(SCL_CFG_OFS, BASE & ~32'h0004_0000 | 32'h0000_0002);
    repeat (4) @(posedge aclk);
    chk_word(32'(recalc_cnt - rc), 32'h1);
    chk_word(32'(clear_cnt - cc), 32'h0);
    wr(SCL_CFG_OFS, BASE);
    repeat (4) @(posedge aclk);
    chk_word(32'(clear_cnt - cc), 32'h1);
    chk_word(32'(recalc_cnt - rc), 32'h1);
  endtask

  task automatic t_bypass;
    logic [31:0] d;
    logic [1:0]  r;
    wr(SCL_CTL_OFS, 32'h0000_0001);
    wr(SCL_CFG_OFS, BASE & ~32'h0000_0E00);
    check_all(BASE & ~32'h0000_0E00, 1'b1, 1'b0);
    rx_pll_locked <= 1'b1;
    repeat (4) @(posedge aclk);
    check_all(BASE & ~32'h0000_0E00, 1'b1, 1'b1);
    axi_read(SCL_STS_OFS, d, r);
    chk_word(d, 32'h0000_0003);
    wr(SCL_CFG_OFS, BASE & ~32'h0001_0000);
    check_all(BASE & ~32'h0001_0000, 1'b1, 1'b1);
    wr(SCL_CFG_OFS, BASE & ~32'h0800_0000);
    check_all(BASE & ~32'h0800_0000, 1'b1, 1'b1);
    wr(SCL_CFG_OFS, BASE);
    rx_pll_locked <= 1'b0;
    repeat (4) @(posedge aclk);
    check_all(BASE, 1'b1, 1'b0);
    wr(SCL_CTL_OFS, 32'h0000_0000);
    check_all(BASE, 1'b0, 1'b0);
    wr(SCL_CFG_OFS, BASE & ~32'h0001_0000);
    check_all(BASE & ~32'h0001_0000, 1'b0, 1'b0);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    err_total = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready, rx_pll_locked} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    check_all(BASE, 1'b0, 1'b0);
    chk_word(32'(recalc_cnt + clear_cnt), 32'h0);
    t_fields();
    t_readback();
    t_pulses();
    t_bypass();
    stop_test();
  end
endmodule
